// ---- pkg/stq_pkg.sv ----
/*
 transmit queue package: register offsets, field positions, reset values,
 serial timing constants for the queued transmit channel.
 assumes a classic wishbone slave with 32-bit data, byte addresses.
*/
package stq_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_QUEUE_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_QUEUE_STATUS = 8'h04;
   localparam logic [7:0] ADDR_SERIAL_DATA = 8'h08;
   localparam logic [7:0] ADDR_CHANNEL_CONTROL = 8'h0c;
   localparam logic [7:0] ADDR_CHANNEL_STATUS = 8'h10;
   localparam logic [7:0] ADDR_TEST_CONTROL = 8'h14;
   localparam logic [7:0] ADDR_TX_SLOT_BASE = 8'h40;
   localparam logic [7:0] ADDR_RX_STATUS_IN = 8'h18;
   // queue_control fields
   localparam int QC_SIZE_LSB = 0;
   localparam int QC_WRAP_BIT = 4;
   localparam int QC_QUEUE_EN_BIT = 6;
   localparam int QC_BOTTOM_IRQ_BIT = 8;
   localparam int QC_TOP_IRQ_BIT = 9;
   // queue_status fields
   localparam int QS_PEND_LSB = 0;
   localparam int QS_RXPNT_LSB = 4;
   localparam int QS_BHE_BIT = 8;
   localparam int QS_THE_BIT = 9;
   localparam int QS_BHF_BIT = 10;
   localparam logic [15:0] QS_RESET = 16'h0f00;
   // channel control/status and test control fields
   localparam int CC_TX_EN_BIT = 0;
   localparam int CS_TC_BIT = 6;
   localparam int CS_TX_DATA_EMPTY_FLAG_BIT = 7;
   localparam int TEST_MODE_BIT = 0;
   // queue geometry
   localparam int SLOTS = 16;
   localparam int FRAME_W = 9;
   localparam logic [3:0] PEND_DONE = 4'hf;
   localparam logic [3:0] HALF_LAST_TOP = 4'h7;
   localparam logic [3:0] HALF_LAST_BOTTOM = 4'hf;
   // serial line timing
   localparam int CLK_HZ = 50_000_000;
   localparam int BAUD = 115_200;
   localparam int BIT_CYCLES = (CLK_HZ + BAUD - 1) / BAUD;
   localparam int FRAME_BITS = 11;
endpackage : stq_pkg

// ---- pkg/stq_shift_if.sv ----
/*
 interface between queue core and serial shifter.
 assumes both ends share clk.
*/
`timescale 1ns/1ps
interface stq_shift_if;
   logic load;
   logic [8:0] data;
   logic busy;
   modport core (output load, output data, input busy);
   modport shifter (input load, input data, output busy);
endinterface : stq_shift_if

// ---- rtl/stq_baud_gen.sv ----
/*
 bit-rate enable divider: one-cycle pulse every bit time.
 assumes the 50 MHz module clock.
*/
`timescale 1ns/1ps
module stq_baud_gen (
   input wire logic clk,
   input wire logic rstn,
   output logic bit_tick
);
   typedef struct packed {
      logic [15:0] cnt;
      logic tick;
   } stq_baud_t;
   stq_baud_t s_reg;
   stq_baud_t s_next;
   always_comb begin
      s_next = s_reg;
      s_next.tick = 1'b0;
      if (s_reg.cnt == 16'(stq_pkg::BIT_CYCLES - 1)) begin
         s_next.cnt = 16'h0000;
         s_next.tick = 1'b1;
      end else begin
         s_next.cnt = s_reg.cnt + 16'h0001;
      end
   end
   always_ff @(posedge clk) begin
      if (!rstn) s_reg <= '0;
      else s_reg <= s_next;
   end
   assign bit_tick = s_reg.tick;
endmodule : stq_baud_gen

// ---- rtl/stq_tx_shifter.sv ----
/*
 transmit serial shifter: start bit, nine data bits lsb first, stop bit.
 assumes bit_tick from the divider; line idles high.
*/
`timescale 1ns/1ps
module stq_tx_shifter (
   input wire logic clk,
   input wire logic rstn,
   input wire logic bit_tick,
   stq_shift_if.shifter sh,
   output logic txd
);
   typedef struct packed {
      logic [10:0] frame;
      logic [3:0] left;
      logic busy;
      logic txd;
   } stq_shift_t;
   stq_shift_t s_reg;
   stq_shift_t s_next;
   always_comb begin
      s_next = s_reg;
      if (!s_reg.busy && sh.load) begin
         s_next.frame = {1'b1, sh.data, 1'b0};
         s_next.left = 4'(stq_pkg::FRAME_BITS);
         s_next.busy = 1'b1;
      end else if (s_reg.busy && bit_tick) begin
         if (s_reg.left == 4'h0) begin
            s_next.busy = 1'b0;
            s_next.txd = 1'b1;
         end else begin
            s_next.txd = s_reg.frame[0];
            s_next.frame = {1'b1, s_reg.frame[10:1]};
            s_next.left = s_reg.left - 4'h1;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (!rstn) s_reg <= '{frame: 11'h7ff, left: 4'h0, busy: 1'b0, txd: 1'b1};
      else s_reg <= s_next;
   end
   assign sh.busy = s_reg.busy;
   assign txd = s_reg.txd;
endmodule : stq_tx_shifter

// ---- rtl/stq_tx_queue.sv ----
/*
 sixteen-slot transmit queue for one serial channel, with wishbone registers.
 assumes a classic wishbone master; rx queue datapath lives elsewhere and
 reports its status through rx_* inputs.
*/
// Summary of operation
// RULE1: queue enable selects queued mode; complete flag takes queued meaning.
// RULE2: queue disabled gives single-buffer transmit; slots are plain 9-bit registers.
// RULE3: sixteen slots, indexed zero to fifteen, sent in order.
// RULE4: wrap at last slot restarts at slot zero and clears wrap enable.
// RULE5: software sends long transfers as full sets of sixteen frames.
// RULE6: top-half-empty bit 9 sets when slots zero to seven sent.
// RULE7: bottom-half-empty bit 8 sets when slots eight to fifteen sent.
// RULE8: half-empty bits clear by status read while set, then zero write.
// RULE9: completion also sets both half-empty bits.
// RULE10: separate enables gate top and bottom half-empty interrupt requests.
// RULE11: software starts queue with enables set, top cleared, data empty set.
// RULE12: four-bit size field, one to sixteen, may be rewritten while running.
// RULE13: pending counter decrements, rolls zero to all ones, test-mode writable.
// RULE14: pending zero means one left; all ones means sixteen or done.
// RULE15: transmit pointer selects next slot; writable only in test mode.
// RULE16: queued complete needs pending all ones and shifter finished.
// RULE17: queued complete clears by status read then slot write.
// RULE18: serial data register writes ignored while queue enabled.
// RULE19: bottom-half-full bit 10 sets when rx slots eight to fifteen fill.
// RULE20: receive pointer at bits 7:4; writable only in test mode.
// RULE21: size loads into pending counter at start and on each wrap.
// RULE22: bottom-half-empty with its enable raises the channel interrupt.
// RULE23: empty data register and pending frames copy slot, advance, decrement.
`timescale 1ns/1ps
module stq_tx_queue (
   input wire logic clk,
   input wire logic rstn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic rx_bottom_full_evt,
   input wire logic rx_slot_advance,
   output logic txd,
   output logic tx_irq
);
   //////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [15:0] queue_control;
      logic tx_enable;
      logic test_mode;
      logic tx_queue_enable_armed;
      logic running;
      logic [3:0] tx_pending_count;
      logic [3:0] tx_slot_pointer;
      logic [3:0] rx_slot_pointer;
      logic tx_top_half_empty;
      logic tx_bottom_half_empty;
      logic rx_bottom_half_full;
      logic [2:0] half_seen;
      logic tx_data_empty_flag;
      logic [8:0] serial_data_register;
      logic tx_complete_flag;
      logic tc_seen;
      logic done_prev;
      logic load;
      logic ack;
      logic [31:0] rdata;
   } stq_core_t;
   stq_core_t s_reg;
   stq_core_t s_next;
   logic [8:0] tx_queue_slot [0:15];
   logic bit_tick;
   stq_shift_if sh ();
   //////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] status_word(input stq_core_t s);
      logic [15:0] w;
      w = 16'h0000;
      w[stq_pkg::QS_PEND_LSB +: 4] = s.tx_pending_count;
      w[stq_pkg::QS_RXPNT_LSB +: 4] = s.rx_slot_pointer;
      w[stq_pkg::QS_BHE_BIT] = s.tx_bottom_half_empty;
      w[stq_pkg::QS_THE_BIT] = s.tx_top_half_empty;
      w[stq_pkg::QS_BHF_BIT] = s.rx_bottom_half_full;
      return w;
   endfunction : status_word
   function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
      return a == b;
   endfunction : hit
   //////////////////////////////////////////////////////////////////////////
   logic req;
   logic wr;
   logic rd;
   logic slot_hit;
   logic [3:0] slot_idx;
   logic queued;
   logic [15:0] wd;
   assign req = wb_cyc_i && wb_stb_i && !s_reg.ack;
   assign wr = req && wb_we_i;
   assign rd = req && !wb_we_i;
   assign slot_hit = wb_adr_i[7:6] == stq_pkg::ADDR_TX_SLOT_BASE[7:6];
   assign slot_idx = wb_adr_i[5:2];
   assign queued = s_reg.queue_control[stq_pkg::QC_QUEUE_EN_BIT];
   assign wd = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00, wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};
   always_comb begin
      logic [3:0] nxt_ptr;
      logic sent_last_top;
      logic sent_last_bot;
      logic done_evt;
      logic done_now;
      nxt_ptr = 4'h0;
      sent_last_top = 1'b0;
      sent_last_bot = 1'b0;
      done_evt = 1'b0;
      done_now = 1'b0;
      s_next = s_reg;
      s_next.ack = req;
      s_next.load = 1'b0;
      // register reads; unmapped addresses read zero
      s_next.rdata = 32'h0000_0000;
      if (rd) begin
         if (hit(wb_adr_i, stq_pkg::ADDR_QUEUE_CONTROL)) s_next.rdata[15:0] = s_reg.queue_control;
         else if (hit(wb_adr_i, stq_pkg::ADDR_QUEUE_STATUS)) begin
            s_next.rdata[15:0] = status_word(s_reg);
            // arm the half flags seen set for a later zero write
            s_next.half_seen = {s_reg.rx_bottom_half_full, s_reg.tx_top_half_empty,
                                s_reg.tx_bottom_half_empty}; // RULE8
         end else if (hit(wb_adr_i, stq_pkg::ADDR_CHANNEL_STATUS)) begin
            s_next.rdata[stq_pkg::CS_TC_BIT] = s_reg.tx_complete_flag;
            s_next.rdata[stq_pkg::CS_TX_DATA_EMPTY_FLAG_BIT] = s_reg.tx_data_empty_flag;
            s_next.tc_seen = s_reg.tx_complete_flag;
         end else if (hit(wb_adr_i, stq_pkg::ADDR_SERIAL_DATA)) s_next.rdata[8:0] = s_reg.serial_data_register;
         else if (hit(wb_adr_i, stq_pkg::ADDR_CHANNEL_CONTROL)) s_next.rdata[0] = s_reg.tx_enable;
         else if (hit(wb_adr_i, stq_pkg::ADDR_TEST_CONTROL)) s_next.rdata[0] = s_reg.test_mode;
         else if (slot_hit) s_next.rdata[8:0] = tx_queue_slot[slot_idx]; // RULE2
      end
      if (wr) begin
         if (hit(wb_adr_i, stq_pkg::ADDR_QUEUE_CONTROL)) begin
            s_next.queue_control = wd & 16'h037f; // RULE12
            // a rising queue enable arms the start
            if (wd[stq_pkg::QC_QUEUE_EN_BIT] && !queued) s_next.tx_queue_enable_armed = 1'b1;
            if (!wd[stq_pkg::QC_QUEUE_EN_BIT]) s_next.running = 1'b0;
         end else if (hit(wb_adr_i, stq_pkg::ADDR_QUEUE_STATUS)) begin
            if (s_reg.half_seen[0] && !wd[stq_pkg::QS_BHE_BIT]) s_next.tx_bottom_half_empty = 1'b0; // RULE8
            if (s_reg.half_seen[1] && !wd[stq_pkg::QS_THE_BIT]) s_next.tx_top_half_empty = 1'b0; // RULE8
            if (s_reg.half_seen[2] && !wd[stq_pkg::QS_BHF_BIT]) s_next.rx_bottom_half_full = 1'b0; // RULE19
            s_next.half_seen = 3'b000;
            if (s_reg.test_mode) begin
               s_next.tx_pending_count = wd[stq_pkg::QS_PEND_LSB +: 4]; // RULE13
               s_next.rx_slot_pointer = wd[stq_pkg::QS_RXPNT_LSB +: 4]; // RULE20
               s_next.tx_slot_pointer = wd[15:12]; // RULE15
            end
         end else if (hit(wb_adr_i, stq_pkg::ADDR_SERIAL_DATA)) begin
            if (!queued) begin // RULE18
               s_next.serial_data_register = wd[8:0];
               s_next.tx_data_empty_flag = 1'b0;
               if (s_reg.tc_seen) s_next.tx_complete_flag = 1'b0; // RULE17
               s_next.tc_seen = 1'b0;
            end
         end else if (hit(wb_adr_i, stq_pkg::ADDR_CHANNEL_CONTROL)) s_next.tx_enable = wd[stq_pkg::CC_TX_EN_BIT];
         else if (hit(wb_adr_i, stq_pkg::ADDR_TEST_CONTROL)) s_next.test_mode = wd[stq_pkg::TEST_MODE_BIT];
         else if (slot_hit) begin
            if (queued && s_reg.tc_seen) s_next.tx_complete_flag = 1'b0; // RULE17
            s_next.tc_seen = 1'b0;
         end
      end
      // start of queued transfer, once software has readied the flags
      if (s_reg.tx_queue_enable_armed && queued && s_reg.tx_enable && !s_next.tx_top_half_empty
          && s_reg.tx_data_empty_flag) begin // RULE11
         s_next.tx_queue_enable_armed = 1'b0;
         s_next.running = 1'b1;
         s_next.tx_slot_pointer = 4'h0;
         s_next.tx_pending_count = s_reg.queue_control[stq_pkg::QC_SIZE_LSB +: 4]; // RULE21
         s_next.tx_complete_flag = 1'b0;
      end
      // feed the serial data register from the queue
      if (queued && s_reg.running && s_reg.tx_data_empty_flag && s_reg.tx_enable && !s_reg.load) begin // RULE23
         s_next.serial_data_register = tx_queue_slot[s_reg.tx_slot_pointer]; // RULE3
         s_next.tx_data_empty_flag = 1'b0;
         nxt_ptr = s_reg.tx_slot_pointer + 4'h1;
         sent_last_top = s_reg.tx_slot_pointer == stq_pkg::HALF_LAST_TOP;
         sent_last_bot = s_reg.tx_slot_pointer == stq_pkg::HALF_LAST_BOTTOM;
         if (s_reg.tx_pending_count == 4'h0) begin
            // last frame of this set
            if (sent_last_bot && s_next.queue_control[stq_pkg::QC_WRAP_BIT]) begin // RULE4
               s_next.queue_control[stq_pkg::QC_WRAP_BIT] = 1'b0;
               s_next.tx_slot_pointer = 4'h0;
               s_next.tx_pending_count = s_next.queue_control[stq_pkg::QC_SIZE_LSB +: 4]; // RULE21
            end else begin
               s_next.tx_pending_count = stq_pkg::PEND_DONE; // RULE14
               s_next.tx_slot_pointer = nxt_ptr;
               s_next.running = 1'b0;
               done_evt = 1'b1;
            end
         end else begin
            s_next.tx_pending_count = s_reg.tx_pending_count - 4'h1; // RULE13
            s_next.tx_slot_pointer = nxt_ptr; // RULE15
         end
         if (sent_last_top || done_evt) s_next.tx_top_half_empty = 1'b1; // RULE6 RULE9
         if (sent_last_bot || done_evt) s_next.tx_bottom_half_empty = 1'b1; // RULE7 RULE9
      end
      // single-buffer and queued hand-off to the shifter
      if (!s_reg.tx_data_empty_flag && !sh.busy && s_reg.tx_enable && !s_reg.load) begin
         s_next.load = 1'b1;
         s_next.tx_data_empty_flag = 1'b1;
      end
      // completion: queued needs pending all ones, both modes need idle shifter
      // set on the rising condition only, else an idle channel would undo every clear
      done_now = s_reg.tx_data_empty_flag && !sh.busy && !s_reg.load && !s_reg.running &&
         (!queued || s_reg.tx_pending_count == stq_pkg::PEND_DONE); // RULE1 RULE16
      s_next.done_prev = done_now;
      if (done_now && !s_reg.done_prev) s_next.tx_complete_flag = 1'b1; // RULE16
      if (rx_bottom_full_evt) s_next.rx_bottom_half_full = 1'b1; // RULE19
      if (rx_slot_advance) s_next.rx_slot_pointer = s_reg.rx_slot_pointer + 4'h1; // RULE20
   end
   //////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_reg <= '0;
         s_reg.tx_top_half_empty <= stq_pkg::QS_RESET[stq_pkg::QS_THE_BIT];
         s_reg.tx_bottom_half_empty <= stq_pkg::QS_RESET[stq_pkg::QS_BHE_BIT];
         s_reg.rx_bottom_half_full <= stq_pkg::QS_RESET[stq_pkg::QS_BHF_BIT];
         s_reg.tx_data_empty_flag <= 1'b1;
         s_reg.tx_complete_flag <= 1'b1;
         s_reg.tx_pending_count <= stq_pkg::PEND_DONE;
      end else begin
         s_reg <= s_next;
      end
   end
   // slots hold data in both modes; no reset so they map to plain storage
   always_ff @(posedge clk) begin
      if (wr && slot_hit) tx_queue_slot[slot_idx] <= wd[8:0]; // RULE2 RULE3
   end
   //////////////////////////////////////////////////////////////////////////
   assign sh.load = s_reg.load;
   assign sh.data = s_reg.serial_data_register;
   stq_baud_gen u_baud (
      .clk(clk),
      .rstn(rstn),
      .bit_tick(bit_tick)
   );
   stq_tx_shifter u_shift (
      .clk(clk),
      .rstn(rstn),
      .bit_tick(bit_tick),
      .sh(sh),
      .txd(txd)
   );
   assign wb_ack_o = s_reg.ack;
   assign wb_dat_o = s_reg.rdata;
   // channel request line; gating is combinational on registered flags
   assign tx_irq = (s_reg.queue_control[stq_pkg::QC_BOTTOM_IRQ_BIT] && s_reg.tx_bottom_half_empty) // RULE22 RULE10
      || (s_reg.queue_control[stq_pkg::QC_TOP_IRQ_BIT] && s_reg.tx_top_half_empty); // RULE10
endmodule : stq_tx_queue

// ---- test/stq_tx_queue_properties.sv ----
/*
 checker on the transmit queue top ports: bus handshake, read data,
 bit timing on txd, interrupt gating, status flags.
 assumes it is bound into stq_tx_queue, one clock domain.
*/
`timescale 1ns/1ps
module stq_tx_queue_properties (
   input wire logic clk,
   input wire logic rstn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic rx_bottom_full_evt,
   input wire logic txd,
   input wire logic tx_irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   logic [1:0] irq_en_reg;
   logic full_seen_reg;
   logic queue_used_reg;
   logic txd_reg;
   logic [15:0] run_reg;
   logic wr_req;
   logic st_rd;
   // writes land at the request edge, so the mirrors follow that edge too
   assign wr_req = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
   assign st_rd = wb_ack_o && !wb_we_i && wb_adr_i == stq_pkg::ADDR_QUEUE_STATUS;
   // mirrors what software wrote and the rx event input; a status write without a prior read just disarms the check
   always_ff @(posedge clk) begin
      if (!rstn) begin
         irq_en_reg <= 2'h0;
         full_seen_reg <= 1'h0;
         queue_used_reg <= 1'h0;
         txd_reg <= 1'h1;
         run_reg <= 16'h0000;
      end else begin
         txd_reg <= txd;
         run_reg <= (txd != txd_reg) ? 16'h0001 : run_reg + 16'h0001;
         if (wr_req && wb_adr_i == stq_pkg::ADDR_QUEUE_CONTROL) begin
            irq_en_reg <= wb_dat_i[9:8];
            if (wb_dat_i[stq_pkg::QC_QUEUE_EN_BIT]) queue_used_reg <= 1'h1;
         end
         if (rx_bottom_full_evt) full_seen_reg <= 1'h1;
         else if (wr_req && wb_adr_i == stq_pkg::ADDR_QUEUE_STATUS) full_seen_reg <= 1'h0;
      end
   end
   ////////////////////////////////////////////////////////////
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ans;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   ack_timing_a: assert property (s_req |=> s_ans) else $error("bus answer is not a one cycle pulse");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
   read_quiet_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
   upper_half_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000) else $error("upper half not zero");
   unmapped_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h30 |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   // low runs only: idle high before a frame has any length
   bit_time_a: assert property (txd && !txd_reg |-> run_reg % stq_pkg::BIT_CYCLES == 0)
      else $error("low run not a whole number of bits");
   irq_gate_a: assert property (irq_en_reg == 2'h0 |-> !tx_irq) else $error("irq with enables clear");
   rx_full_a: assert property (st_rd && full_seen_reg |-> wb_dat_o[stq_pkg::QS_BHF_BIT])
      else $error("rx bottom full not shown");
   pend_idle_a: assert property (st_rd && !queue_used_reg |-> wb_dat_o[3:0] == stq_pkg::PEND_DONE)
      else $error("pending not all ones before any queue");
endmodule : stq_tx_queue_properties
bind stq_tx_queue stq_tx_queue_properties u_stq_tx_queue_properties (.clk(clk), .rstn(rstn),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .rx_bottom_full_evt(rx_bottom_full_evt), .txd(txd), .tx_irq(tx_irq));

// ---- test/stq_line_rx.sv ----
/*
 remote line receiver: start, nine data bits lsb first, stop.
 assumes txd idles high and bits last stq_pkg::BIT_CYCLES clocks.
*/
`timescale 1ns/1ps
module stq_line_rx (
   input wire logic clk,
   input wire logic rxd,
   output logic got,
   output logic [8:0] frame,
   output logic bad
);
   initial begin
      got = 1'h0;
      bad = 1'h0;
      frame = 9'h000;
      forever begin
         @(negedge rxd);
         // sample mid bit so edge jitter of one clock cannot shift a bit
         repeat (stq_pkg::BIT_CYCLES / 2) @(posedge clk);
         for (int i = 0; i < 10; i++) begin
            repeat (stq_pkg::BIT_CYCLES) @(posedge clk);
            if (i < 9) frame[i] = rxd;
            else bad = !rxd;
         end
         got = 1'h1;
         @(posedge clk);
         got = 1'h0;
         bad = 1'h0;
      end
   end
endmodule : stq_line_rx

// ---- test/tb_stq_tx_queue.sv ----
/*
 testbench for the transmit queue: register rows, flag clearing, rx status,
 queued and single-buffer frames on the line.
 assumes the line model and the checker are compiled before it.
*/
`timescale 1ns/1ps
module tb_stq_tx_queue;
   typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic q;} stq_row_t;
   localparam logic [7:0] QC = stq_pkg::ADDR_QUEUE_CONTROL;
   localparam logic [7:0] QS = stq_pkg::ADDR_QUEUE_STATUS;
   localparam logic [7:0] CS = stq_pkg::ADDR_CHANNEL_STATUS;
   localparam logic [7:0] SQ = stq_pkg::ADDR_TX_SLOT_BASE;
   localparam stq_row_t ROWS [6] = '{'{1'h0, QS, 32'h0, 32'h070f, 1'h0}, '{1'h0, CS, 32'h0, 32'h00c0, 1'h0},
      '{1'h1, SQ, 32'h3ff, 32'h01ff, 1'h0}, '{1'h1, SQ + 8'h3c, 32'h0a5, 32'h00a5, 1'h0},
      '{1'h1, 8'h30, 32'hffff, 32'h0, 1'h0}, '{1'h1, QC, 32'h300, 32'h0300, 1'h1}};
   localparam logic [8:0] QD [3] = '{9'h101, 9'h0c3, 9'h055};
   logic clk = 1'h0;
   logic rstn = 1'h0;
   logic req = 1'h0;
   logic we = 1'h0;
   logic evt = 1'h0;
   logic adv = 1'h0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat, dat_o;
   logic ack, txd, irq, got, bad;
   logic [8:0] frame;
   logic [8:0] seen [$];
   int n_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   always #10 clk = ~clk;
   stq_tx_queue u_stq_tx_queue (.clk(clk), .rstn(rstn), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .rx_bottom_full_evt(evt), .rx_slot_advance(adv), .txd(txd), .tx_irq(irq));
   stq_line_rx u_stq_line_rx (.clk(clk), .rxd(txd), .got(got), .frame(frame), .bad(bad));
   ////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("checks %0d, errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got_v);
      total_checks++;
      if (got_v !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got_v);
      end
   endtask : cmp
   // called just after a rising edge; holds the request until ack is sampled high,
   // then releases and lets one edge pass with cyc and stb low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      req <= 1'h1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk);
      end while (ack !== 1'h1);
      rdat = dat_o;
      cmp("ack", 32'h1, {31'h0, ack});
      req <= 1'h0;
      @(posedge clk);
   endtask : bus
   always @(posedge got) begin
      seen.push_back(frame);
      cmp("stop bit", 32'h0, {31'h0, bad});
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         n_errors++;
         report_and_stop();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1'h1;
      foreach (ROWS[i]) begin
         bus(ROWS[i].w, ROWS[i].a, ROWS[i].d);
         if (ROWS[i].w) bus(1'h0, ROWS[i].a, 32'h0);
         cmp("register", ROWS[i].e, rdat);
         cmp("irq", {31'h0, ROWS[i].q}, {31'h0, irq});
      end
      bus(1'h0, QS, 32'h0);
      bus(1'h1, QS, 32'h0);
      bus(1'h0, QS, 32'h0);
      cmp("status cleared", 32'h000f, rdat);
      cmp("irq", 32'h0, {31'h0, irq});
      repeat (3) begin
         adv <= 1'h1;
         @(posedge clk);
         adv <= 1'h0;
         @(posedge clk);
      end
      evt <= 1'h1;
      @(posedge clk);
      evt <= 1'h0;
      bus(1'h0, QS, 32'h0);
      cmp("rx status", 32'h043f, rdat);
      bus(1'h1, QS, 32'h0);
      bus(1'h0, QS, 32'h0);
      cmp("rx full cleared", 32'h003f, rdat);
      foreach (QD[i]) bus(1'h1, SQ + 8'(4 * i), {23'h0, QD[i]});
      bus(1'h1, stq_pkg::ADDR_CHANNEL_CONTROL, 32'h1);
      bus(1'h1, QC, 32'h42);
      bus(1'h1, stq_pkg::ADDR_SERIAL_DATA, 32'h1aa);
      while (seen.size() < 3) @(posedge clk);
      repeat (600) @(posedge clk);
      bus(1'h0, QS, 32'h0);
      // the top nibble holds no pointer bits and reads zero; the mask drops it
      cmp("status done", 32'h033f, rdat & 32'h0fff);
      foreach (QD[i]) cmp("frame", {23'h0, QD[i]}, {23'h0, seen[i]});
      bus(1'h0, CS, 32'h0);
      cmp("complete", 32'h40, rdat & 32'h40);
      bus(1'h1, SQ, 32'h0);
      bus(1'h0, CS, 32'h0);
      cmp("complete cleared", 32'h0, rdat & 32'h40);
      repeat (5000) @(posedge clk);
      cmp("frame count", 32'h3, seen.size());
      bus(1'h1, QC, 32'h0);
      bus(1'h1, stq_pkg::ADDR_SERIAL_DATA, 32'h1c4);
      while (seen.size() < 4) @(posedge clk);
      cmp("single frame", 32'h1c4, {23'h0, seen[3]});
      report_and_stop();
   end
endmodule : tb_stq_tx_queue
